/* rtl/gle_regs.svh */
`ifndef GLE_REGS_SVH
`define GLE_REGS_SVH
`define GLE_ADDR_PULL 8'h1a
`define GLE_ADDR_POL_LO 8'h1b
`define GLE_ADDR_POL_HI 8'h1c
`define GLE_ADDR_QEN_LO 8'h1d
`define GLE_ADDR_QEN_HI 8'h1e
`define GLE_ADDR_INTEN_LO 8'h1f
`define GLE_ADDR_INTEN_HI 8'h20
`define GLE_ADDR_FLAG_LO 8'h13
`define GLE_ADDR_FLAG_HI 8'h14
`define GLE_RST_PULL 2'h1
`define GLE_LO_N 6
`define GLE_HI_N 5
`define GLE_N 11
`define GLE_PULL_UP_WEAK 2'h0
`define GLE_PULL_DOWN 2'h1
`define GLE_PULL_UP_STRONG 2'h2
`define GLE_PULL_NONE 2'h3
`endif

/* rtl/gle_pkg.sv */
package gle_pkg;
	typedef enum logic [1:0] {
		GLE_PULL_UP_WEAK_E = 2'h0,
		GLE_PULL_DOWN_E = 2'h1,
		GLE_PULL_UP_STRONG_E = 2'h2,
		GLE_PULL_OFF_E = 2'h3
	} gle_pull_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} gle_req_t;
	typedef struct packed {
		logic pull_up_weak;
		logic pull_down;
		logic pull_up_strong;
	} gle_pad_t;
endpackage : gle_pkg

/* rtl/gle_gpi_level_event_config.sv */
// What this block does
// RULE1: Pull select 00 weak-up,01 down,10 strong-up,11 none
// RULE2: Polarity bit 0 flags input while low
// RULE3: Polarity bit 1 flags input while high
// RULE4: Low polarity group bits 0-5, 7:6 reserved
// RULE5: High polarity group bits 0-4, 7:5 reserved
// RULE6: Queue enable clear gives no queue entries
// RULE7: Queue enable set records activity in queue
// RULE8: Queue enable bits 0-5 and 0-4 layout
// RULE9: Queued input activity raises queue event flag
// RULE10: Queued input never raises general input flag
// RULE11: Queued input events feed unlock logic
// RULE12: Per-input flag sets, clears on host read
// RULE13: Enabled raised flag drives summary interrupt bit
// RULE14: Reserved bits ignore writes, read zero
`timescale 1ns/100ps
`include "gle_regs.svh"
module gle_gpi_level_event_config
	import gle_pkg::*;
#(
	parameter int N_INPUTS = `GLE_N
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic clk_en_i,
	input wire gle_req_t req_i,
	input wire logic [N_INPUTS-1:0] general_input_i,
	output logic [7:0] rdata_o,
	output gle_pad_t last_column_pad_o,
	output logic [N_INPUTS-1:0] queue_event_o,
	output logic [N_INPUTS-1:0] unlock_event_o,
	output logic queue_event_interrupt_flag_o,
	output logic summary_input_interrupt_flag_o
);
	// ========================================
	// Registers
	logic [1:0] last_column_pull_select_field;
	logic [N_INPUTS-1:0] input_polarity_bit;
	logic [N_INPUTS-1:0] input_queue_enable_bit;
	logic [N_INPUTS-1:0] input_interrupt_enable;
	logic [N_INPUTS-1:0] per_input_interrupt_flag;
	logic [N_INPUTS-1:0] prev_input;

	function automatic logic [7:0] gle_lo(input logic [N_INPUTS-1:0] v);
		return {2'h0, v[`GLE_LO_N-1:0]};
	endfunction : gle_lo
	function automatic logic [7:0] gle_hi(input logic [N_INPUTS-1:0] v);
		return {3'h0, v[N_INPUTS-1:`GLE_LO_N]};
	endfunction : gle_hi

	// ========================================
	// Decode
	wire logic wr_pull = req_i.wr && req_i.addr == `GLE_ADDR_PULL;
	wire logic wr_pol_lo = req_i.wr && req_i.addr == `GLE_ADDR_POL_LO;
	wire logic wr_pol_hi = req_i.wr && req_i.addr == `GLE_ADDR_POL_HI;
	wire logic wr_qen_lo = req_i.wr && req_i.addr == `GLE_ADDR_QEN_LO;
	wire logic wr_qen_hi = req_i.wr && req_i.addr == `GLE_ADDR_QEN_HI;
	wire logic wr_ien_lo = req_i.wr && req_i.addr == `GLE_ADDR_INTEN_LO;
	wire logic wr_ien_hi = req_i.wr && req_i.addr == `GLE_ADDR_INTEN_HI;
	wire logic rd_flag_lo = req_i.rd && req_i.addr == `GLE_ADDR_FLAG_LO;
	wire logic rd_flag_hi = req_i.rd && req_i.addr == `GLE_ADDR_FLAG_HI;
	// Level condition per input, polarity selects the active level
	wire logic [N_INPUTS-1:0] level_hit = ~(general_input_i ^ input_polarity_bit); // RULE2 RULE3
	// Inputs in queue mode never set the general flag
	wire logic [N_INPUTS-1:0] flag_set = level_hit & ~input_queue_enable_bit; // RULE10
	wire logic [N_INPUTS-1:0] activity = general_input_i ^ prev_input;
	wire logic [N_INPUTS-1:0] next_queue_event = activity & input_queue_enable_bit; // RULE6 RULE7
	wire logic [N_INPUTS-1:0] flag_clr = {{`GLE_HI_N{rd_flag_hi}}, {`GLE_LO_N{rd_flag_lo}}};
	// Set wins over clear-on-read
	wire logic [N_INPUTS-1:0] next_flag = (per_input_interrupt_flag & ~flag_clr) | flag_set; // RULE12
	wire logic next_summary = |(next_flag & input_interrupt_enable); // RULE13
	wire logic [7:0] next_rdata =
		(req_i.addr == `GLE_ADDR_PULL) ? {6'h0, last_column_pull_select_field} :
		(req_i.addr == `GLE_ADDR_POL_LO) ? gle_lo(input_polarity_bit) : // RULE4 RULE14
		(req_i.addr == `GLE_ADDR_POL_HI) ? gle_hi(input_polarity_bit) : // RULE5 RULE14
		(req_i.addr == `GLE_ADDR_QEN_LO) ? gle_lo(input_queue_enable_bit) : // RULE8
		(req_i.addr == `GLE_ADDR_QEN_HI) ? gle_hi(input_queue_enable_bit) : // RULE8
		(req_i.addr == `GLE_ADDR_INTEN_LO) ? gle_lo(input_interrupt_enable) :
		(req_i.addr == `GLE_ADDR_INTEN_HI) ? gle_hi(input_interrupt_enable) :
		rd_flag_lo ? gle_lo(per_input_interrupt_flag) :
		rd_flag_hi ? gle_hi(per_input_interrupt_flag) : 8'h00;
	wire gle_pull_t pull_sel = gle_pull_t'(last_column_pull_select_field);
	wire gle_pad_t next_pad = '{
		pull_up_weak: pull_sel == GLE_PULL_UP_WEAK_E,
		pull_down: pull_sel == GLE_PULL_DOWN_E,
		pull_up_strong: pull_sel == GLE_PULL_UP_STRONG_E}; // RULE1

	// ========================================
	// Configuration
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			last_column_pull_select_field <= `GLE_RST_PULL;
			input_polarity_bit <= '0;
			input_queue_enable_bit <= '0;
			input_interrupt_enable <= '0;
		end else if (clk_en_i) begin
			if (wr_pull)
				last_column_pull_select_field <= req_i.wdata[1:0]; // RULE14
			if (wr_pol_lo)
				input_polarity_bit[`GLE_LO_N-1:0] <= req_i.wdata[`GLE_LO_N-1:0]; // RULE4
			if (wr_pol_hi)
				input_polarity_bit[N_INPUTS-1:`GLE_LO_N] <= req_i.wdata[`GLE_HI_N-1:0]; // RULE5
			if (wr_qen_lo)
				input_queue_enable_bit[`GLE_LO_N-1:0] <= req_i.wdata[`GLE_LO_N-1:0]; // RULE8
			if (wr_qen_hi)
				input_queue_enable_bit[N_INPUTS-1:`GLE_LO_N] <= req_i.wdata[`GLE_HI_N-1:0]; // RULE8
			if (wr_ien_lo)
				input_interrupt_enable[`GLE_LO_N-1:0] <= req_i.wdata[`GLE_LO_N-1:0];
			if (wr_ien_hi)
				input_interrupt_enable[N_INPUTS-1:`GLE_LO_N] <= req_i.wdata[`GLE_HI_N-1:0];
		end
	end

	// ========================================
	// Status and events
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			per_input_interrupt_flag <= '0;
			prev_input <= general_input_i;
			queue_event_o <= '0;
			unlock_event_o <= '0;
			queue_event_interrupt_flag_o <= 1'b0;
			summary_input_interrupt_flag_o <= 1'b0;
			rdata_o <= 8'h00;
			last_column_pad_o <= '0;
		end else if (clk_en_i) begin
			per_input_interrupt_flag <= next_flag;
			prev_input <= general_input_i;
			queue_event_o <= next_queue_event;
			unlock_event_o <= next_queue_event; // RULE11
			queue_event_interrupt_flag_o <= |next_queue_event; // RULE9
			summary_input_interrupt_flag_o <= next_summary;
			rdata_o <= next_rdata;
			last_column_pad_o <= next_pad;
		end
	end

	// ========================================
	// Checks
	AST_QUEUED_NO_FLAG: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE10
		clk_en_i |=> (per_input_interrupt_flag & ~$past(per_input_interrupt_flag) &
		$past(input_queue_enable_bit)) == '0)
		else $error("queued input raised its general flag");
	AST_LEVEL_SET: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE2
		clk_en_i && (flag_set != '0) |=> ((per_input_interrupt_flag & $past(flag_set)) == $past(flag_set)))
		else $error("level hit did not set flag");
	AST_POL_HIGH: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE3
		clk_en_i && general_input_i[0] && input_polarity_bit[0] && !input_queue_enable_bit[0]
		|=> per_input_interrupt_flag[0])
		else $error("active high input 0 not flagged");
	AST_RD_CLEAR: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE12
		clk_en_i && rd_flag_lo && flag_set[`GLE_LO_N-1:0] == '0
		|=> per_input_interrupt_flag[`GLE_LO_N-1:0] == '0)
		else $error("flags not cleared on read");
	AST_QUEUE_INT: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE9
		clk_en_i && (next_queue_event != '0) |=> queue_event_interrupt_flag_o && unlock_event_o != '0)
		else $error("queue activity missed interrupt");
	AST_NO_QUEUE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE6
		clk_en_i |=> (queue_event_o & ~$past(input_queue_enable_bit)) == '0)
		else $error("disabled input queued");
	AST_QUEUE_REC: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE7
		clk_en_i && input_queue_enable_bit[0] && activity[0] |=> queue_event_o[0])
		else $error("enabled activity not queued");
	AST_SUMMARY: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE13
		clk_en_i |=> summary_input_interrupt_flag_o ==
		|(per_input_interrupt_flag & $past(input_interrupt_enable)))
		else $error("summary flag mismatch");
	AST_RSV_ZERO: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE14
		clk_en_i && req_i.addr == `GLE_ADDR_POL_HI |=> rdata_o[7:5] == 3'h0)
		else $error("reserved bits read nonzero");
	AST_PULL: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE1
		clk_en_i && last_column_pull_select_field == `GLE_PULL_NONE |=> last_column_pad_o == '0)
		else $error("pull active when disabled");
	AST_POL_LOW: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE2
		clk_en_i && !general_input_i[0] && !input_polarity_bit[0] && !input_queue_enable_bit[0]
		|=> per_input_interrupt_flag[0])
		else $error("active low input 0 not flagged");
	AST_WR_PULL: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE1
		clk_en_i && wr_pull |=> last_column_pull_select_field == $past(req_i.wdata[1:0]))
		else $error("pull select write lost");
	AST_PAD_ONEHOT: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE1
		clk_en_i |=> $onehot0(last_column_pad_o))
		else $error("more than one pull enabled");
	AST_RSV_PULL: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE14
		clk_en_i && req_i.addr == `GLE_ADDR_PULL |=> rdata_o[7:2] == 6'h0)
		else $error("reserved pull bits read nonzero");
	AST_RSV_LO: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE4
		clk_en_i && req_i.addr == `GLE_ADDR_POL_LO |=> rdata_o[7:6] == 2'h0)
		else $error("reserved low group bits read nonzero");
	AST_WR_POL_HI: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE5
		clk_en_i && wr_pol_hi |=>
		input_polarity_bit[N_INPUTS-1:`GLE_LO_N] == $past(req_i.wdata[`GLE_HI_N-1:0]))
		else $error("high polarity group write lost");
	AST_WR_QEN_LO: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE8
		clk_en_i && wr_qen_lo |=>
		input_queue_enable_bit[`GLE_LO_N-1:0] == $past(req_i.wdata[`GLE_LO_N-1:0]))
		else $error("low queue enable write lost");
	AST_NO_QUEUE_INT: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE6
		clk_en_i && next_queue_event == '0 |=> !queue_event_interrupt_flag_o)
		else $error("queue interrupt without activity");
	AST_UNLOCK: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE11
		clk_en_i |=> unlock_event_o ==
		($past(general_input_i ^ prev_input) & $past(input_queue_enable_bit)))
		else $error("unlock event mismatch");
	AST_RD_FLAG: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE12
		clk_en_i && rd_flag_lo |=>
		rdata_o[`GLE_LO_N-1:0] == $past(per_input_interrupt_flag[`GLE_LO_N-1:0]))
		else $error("flag read data mismatch");
	AST_SET_WINS: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE12
		clk_en_i && rd_flag_lo && flag_set[0] |=> per_input_interrupt_flag[0])
		else $error("read clear beat a live condition");
	AST_FREEZE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE12
		!clk_en_i |=> $stable(rdata_o) && $stable(queue_event_o) &&
		$stable(per_input_interrupt_flag) && $stable(last_column_pad_o))
		else $error("state moved while frozen");

	// ========================================
	// Coverage
	COV_QUEUE: cover property (@(posedge core_clk_i) queue_event_interrupt_flag_o);
	COV_SUMMARY: cover property (@(posedge core_clk_i) summary_input_interrupt_flag_o);
	COV_RD_SET: cover property (@(posedge core_clk_i) rd_flag_lo && flag_set[0]);
	COV_FREEZE: cover property (@(posedge core_clk_i) !clk_en_i ##1 clk_en_i ##1 queue_event_o != '0);
	COV_PULL_OFF: cover property (@(posedge core_clk_i) last_column_pull_select_field == `GLE_PULL_NONE);
endmodule : gle_gpi_level_event_config

/* dv/gle_host_model.sv */
`timescale 1ns/100ps
module gle_host_model
	import gle_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic [7:0] rdata_i,
	output gle_req_t req_o
);
	// ==========
	// Register access, held from just after one edge to the next
	initial begin
		req_o = '0;
	end
	task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] r);
		@(posedge core_clk_i);
		#1;
		req_o = '{w, !w, a, d};
		@(posedge core_clk_i);
		#1;
		r = rdata_i;
		req_o = '{1'b0, 1'b0, ~a, ~d};
	endtask : access
endmodule : gle_host_model

/* dv/tb.sv */
`timescale 1ns/100ps
`include "gle_regs.svh"
module tb;
	import gle_pkg::*;
	logic core_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [10:0] gin = '0;
	gle_req_t req;
	gle_pad_t pad;
	logic [7:0] rdata, rd;
	logic [10:0] qev, uev, qa, ua, cond, pol;
	logic qf, sf, fa;
	logic en = 1'b1;
	int err_total = 0;
	int tests_run = 0;
	always #25 core_clk_i = ~core_clk_i;
	gle_gpi_level_event_config gle_gpi_level_event_config_inst (.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i), .clk_en_i(en), .req_i(req), .general_input_i(gin),
		.rdata_o(rdata), .last_column_pad_o(pad), .queue_event_o(qev), .unlock_event_o(uev),
		.queue_event_interrupt_flag_o(qf), .summary_input_interrupt_flag_o(sf));
	gle_host_model gle_host_model_inst (.core_clk_i(core_clk_i), .rdata_i(rdata), .req_o(req));
	// ==========
	// Helpers
	task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		gle_host_model_inst.access(w, a, d, rd);
	endtask : acc
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		acc(1'b0, a, 8'h00);
		chk("read data", {3'h0, exp}, {3'h0, rd});
	endtask : rchk
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask : tick
	task automatic watch();
		qa = '0;
		ua = '0;
		fa = 1'b0;
		repeat (3) begin
			tick(1);
			qa |= qev;
			ua |= uev;
			fa |= qf;
		end
	endtask : watch
	function automatic logic [2:0] pad_exp(input logic [1:0] s);
		return (s == 2'h3) ? 3'h0 : 3'h4 >> s;
	endfunction : pad_exp
	task automatic stop_test();
		$display("checks %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test
	initial begin
		#(3000 * 50);
		err_total++;
		stop_test();
	end
	// ==========
	// Main sequence
	initial begin
		void'($urandom(32'hdfb1));
		tick(3);
		rst_n_i = 1'b1;
		rchk(`GLE_ADDR_PULL, 8'h01);
		for (int s = 0; s < 4; s++) begin
			acc(1'b1, `GLE_ADDR_PULL, 8'hfc | s[7:0]);
			tick(2);
			chk("pad", {8'h0, pad_exp(s[1:0])}, {8'h0, pad});
			rchk(`GLE_ADDR_PULL, s[7:0]);
		end
		for (int a = 8'h1b; a <= 8'h1e; a++) begin
			acc(1'b1, a[7:0], 8'hff);
			rchk(a[7:0], a[0] ? 8'h3f : 8'h1f);
		end
		acc(1'b1, `GLE_ADDR_QEN_LO, 8'h00);
		acc(1'b1, `GLE_ADDR_QEN_HI, 8'h00);
		acc(1'b1, 8'h30, 8'h5a);
		rchk(8'h30, 8'h00);
		acc(1'b1, `GLE_ADDR_INTEN_LO, 8'h3f);
		acc(1'b1, `GLE_ADDR_INTEN_HI, 8'h1f);
		for (int i = 0; i < 8; i++) begin
			pol = (i == 0) ? '0 : (i == 1) ? '1 : 11'($urandom);
			gin = (i < 2) ? '0 : 11'($urandom);
			cond = ~(gin ^ pol);
			acc(1'b1, `GLE_ADDR_POL_LO, {2'h0, pol[5:0]});
			acc(1'b1, `GLE_ADDR_POL_HI, {3'h0, pol[10:6]});
			acc(1'b0, `GLE_ADDR_FLAG_LO, 8'h00);
			acc(1'b0, `GLE_ADDR_FLAG_HI, 8'h00);
			rchk(`GLE_ADDR_FLAG_LO, {2'h0, cond[5:0]});
			rchk(`GLE_ADDR_FLAG_HI, {3'h0, cond[10:6]});
			chk("summary", {10'h0, |cond}, {10'h0, sf});
		end
		acc(1'b1, `GLE_ADDR_QEN_LO, 8'h3f);
		acc(1'b1, `GLE_ADDR_QEN_HI, 8'h1f);
		for (int k = 0; k < 11; k++) begin
			gin[k] = ~gin[k];
			watch();
			chk("queue event", 11'(1) << k, qa);
			chk("unlock event", 11'(1) << k, ua);
			chk("queue flag", 11'h1, {10'h0, fa});
		end
		acc(1'b0, `GLE_ADDR_FLAG_LO, 8'h00);
		acc(1'b0, `GLE_ADDR_FLAG_HI, 8'h00);
		rchk(`GLE_ADDR_FLAG_LO, 8'h00);
		rchk(`GLE_ADDR_FLAG_HI, 8'h00);
		chk("summary", 11'h0, {10'h0, sf});
		acc(1'b1, `GLE_ADDR_QEN_LO, 8'h00);
		gin[0] = ~gin[0];
		watch();
		chk("queue event", 11'h0, qa);
		acc(1'b1, `GLE_ADDR_INTEN_HI, 8'h00);
		acc(1'b1, `GLE_ADDR_POL_LO, {6'h0, ~gin[1], gin[0]});
		acc(1'b0, `GLE_ADDR_FLAG_LO, 8'h00);
		acc(1'b1, `GLE_ADDR_INTEN_LO, 8'h02);
		tick(1);
		chk("summary", 11'h0, {10'h0, sf});
		acc(1'b1, `GLE_ADDR_INTEN_LO, 8'h01);
		tick(1);
		chk("summary", 11'h1, {10'h0, sf});
		en = 1'b0;
		acc(1'b1, `GLE_ADDR_PULL, 8'h02);
		gin[6] = ~gin[6];
		watch();
		chk("frozen queue event", 11'h0, qa);
		chk("frozen pad", {8'h0, pad_exp(2'h3)}, {8'h0, pad});
		en = 1'b1;
		watch();
		chk("resumed queue event", 11'h40, qa);
		rchk(`GLE_ADDR_PULL, 8'h03);
		rst_n_i = 1'b0;
		tick(3);
		rst_n_i = 1'b1;
		tick(1);
		chk("reset pad", 11'h2, {8'h0, pad});
		rchk(`GLE_ADDR_PULL, 8'h01);
		stop_test();
	end
endmodule : tb
